// >>> src/scrs_pkg.sv
/*
 * Constants for the system clock and reset select block: reset filter length,
 * pin encodings and the PLL multiplication factors in tenths.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package scrs_pkg;
   // ---------------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS     = 20;
   localparam int unsigned RST_FILTER_CYCLES = 64;    // Least low time, master clocks
   localparam int unsigned RST_CNT_W         = 7;
   localparam logic [6:0]  RST_CNT_MAX       = 7'(RST_FILTER_CYCLES);

   // ---------------------------------------------------------------------
   // Pin encodings
   // ---------------------------------------------------------------------
   localparam logic SEL_PLL    = 1'b0;
   localparam logic SEL_EXT    = 1'b1;
   localparam logic MODE_NORM  = 1'b0;
   localparam logic MODE_TEST  = 1'b1;

   // ---------------------------------------------------------------------
   // PLL multiplication factor, in tenths
   // ---------------------------------------------------------------------
   localparam logic [6:0] MF_NORMAL_X10 = 7'h32;      // 5.0
   localparam logic [6:0] MF_TEST_X10   = 7'h42;      // 6.6

   // Reset filter states
   typedef enum logic [2:0] {
      RF_RUN    = 3'h1,
      RF_COUNT  = 3'h2,
      RF_RESET  = 3'h4
   } scrs_rf_state_t;
endpackage

// >>> src/scrs_top.sv
/*
 * System clock select, clock output, test mode and reset filtering.
 * Assumes: mclk_i is the 50 MHz master clock domain in which the selection
 * result is used; the analog PLL sits outside and is steered by the factor
 * output; clock muxing is modelled as a select to the glitch-free clock cell.
 */
`timescale 1ns/1ps

// Overview of operation
// - With the source select low the PLL output is the master clock.
// - With the source select high the external clock bypasses the PLL.
// - In normal mode the PLL multiplies its input clock by five.
// - Test select low means normal mode, high means chip test mode.
// - With test select high the PLL factor changes from five to 6.6.
// - The system clock output follows the master clock in phase and doubles as SDRAM clock.
// - The clock output enable pin turns driving of the system clock output on or off.
// - The scan logic reset acts asynchronously whenever its low-active pin is asserted.
module scrs_top (
   input  wire logic       mclk_i,
   input  wire logic       srst_i,
   input  wire logic       ext_clock_in_i,
   input  wire logic       pll_clock_in_i,
   input  wire logic       clock_source_select_i,
   input  wire logic       test_mode_select_i,
   input  wire logic       clock_out_enable_i,
   input  wire logic       global_reset_in_n_i,
   input  wire logic       scan_logic_reset_n_i,
   output logic            master_clock_o,
   output logic            sys_clock_out_o,
   output logic            sys_clock_out_oe_o,
   output logic            sdram_clock_out_o,
   output logic            use_pll_reg_o,
   output logic            test_mode_o,
   output logic [6:0]      pll_multiply_factor_o,
   output logic            sys_reset_o,
   output logic            scan_reset_o
);

   // ---------------------------------------------------------------------
   // Clock source selection
   // ---------------------------------------------------------------------
   logic use_pll_reg;
   logic test_mode_reg;
   logic [6:0] mf_reg;

   // Select is registered; the clock path itself stays combinational
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         use_pll_reg <= 1'b1;
      end else begin
         use_pll_reg <= (clock_source_select_i == scrs_pkg::SEL_PLL);
      end
   end

   // Master clock mux; a real chip uses a glitch-free cell here
   assign master_clock_o = clock_source_select_i ? ext_clock_in_i
                                                 : pll_clock_in_i;

   // ---------------------------------------------------------------------
   // Test mode and PLL factor
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         test_mode_reg <= 1'b0;
         mf_reg        <= scrs_pkg::MF_NORMAL_X10;
      end else begin
         test_mode_reg <= (test_mode_select_i == scrs_pkg::MODE_TEST);
         mf_reg        <= test_mode_select_i ? scrs_pkg::MF_TEST_X10
                                             : scrs_pkg::MF_NORMAL_X10;
      end
   end

   assign use_pll_reg_o         = use_pll_reg;
   assign test_mode_o           = test_mode_reg;
   assign pll_multiply_factor_o = mf_reg;

   // ---------------------------------------------------------------------
   // Clock output pin
   // ---------------------------------------------------------------------
   // Same net as master clock keeps the output in phase with it
   assign sys_clock_out_o    = master_clock_o;
   assign sdram_clock_out_o  = master_clock_o;
   assign sys_clock_out_oe_o = clock_out_enable_i;

   // ---------------------------------------------------------------------
   // Global reset filter
   // ---------------------------------------------------------------------
   scrs_pkg::scrs_rf_state_t rf_state_reg;
   scrs_pkg::scrs_rf_state_t rf_state_next;
   logic [6:0] low_cnt_reg;
   logic [6:0] low_cnt_next;

   // Short glitches restart the count, so only a long low resets the system
   always_comb begin
      rf_state_next = rf_state_reg;
      low_cnt_next  = low_cnt_reg;
      case (rf_state_reg)
         scrs_pkg::RF_RUN: begin
            low_cnt_next = 7'h00;
            if (!global_reset_in_n_i) begin
               rf_state_next = scrs_pkg::RF_COUNT;
               low_cnt_next  = 7'h01;
            end
         end
         scrs_pkg::RF_COUNT: begin
            if (global_reset_in_n_i) begin
               rf_state_next = scrs_pkg::RF_RUN;
               low_cnt_next  = 7'h00;
            end else if (low_cnt_reg == scrs_pkg::RST_CNT_MAX - 7'h01) begin
               rf_state_next = scrs_pkg::RF_RESET;
               low_cnt_next  = scrs_pkg::RST_CNT_MAX;
            end else begin
               low_cnt_next = low_cnt_reg + 7'h01;
            end
         end
         scrs_pkg::RF_RESET: begin
            if (global_reset_in_n_i) begin
               rf_state_next = scrs_pkg::RF_RUN;
               low_cnt_next  = 7'h00;
            end
         end
         default: begin
            rf_state_next = scrs_pkg::RF_RUN;
            low_cnt_next  = 7'h00;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rf_state_reg <= scrs_pkg::RF_RUN;
         low_cnt_reg  <= 7'h00;
      end else begin
         rf_state_reg <= rf_state_next;
         low_cnt_reg  <= low_cnt_next;
      end
   end

   assign sys_reset_o = (rf_state_reg == scrs_pkg::RF_RESET);

   // ---------------------------------------------------------------------
   // Scan logic reset
   // ---------------------------------------------------------------------
   // Purely combinational: must act with no clock running at all
   assign scan_reset_o = ~scan_logic_reset_n_i;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   sequence s_low_run;
      !global_reset_in_n_i [*8];
   endsequence

   property p_pll_sel;
      @(posedge mclk_i) disable iff (srst_i)
         !clock_source_select_i |-> master_clock_o == pll_clock_in_i;
   endproperty
   a_pll_sel: assert property (p_pll_sel) else $error("PLL not selected");

   property p_ext_sel;
      @(posedge mclk_i) disable iff (srst_i)
         clock_source_select_i |-> master_clock_o == ext_clock_in_i;
   endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("External clock not selected");

   property p_no_early_reset;
      @(posedge mclk_i) disable iff (srst_i)
         $rose(sys_reset_o) |-> low_cnt_reg == scrs_pkg::RST_CNT_MAX;
   endproperty
   a_no_early_reset: assert property (p_no_early_reset) else $error("Reset too early");

   // Reset sampled at the launch edge makes the attempt vacuous, so release is clean
   property p_mf_norm;
      @(posedge mclk_i) disable iff (srst_i)
         !srst_i && !test_mode_select_i |=> pll_multiply_factor_o == scrs_pkg::MF_NORMAL_X10;
   endproperty
   a_mf_norm: assert property (p_mf_norm) else $error("Factor not five");

   property p_mode;
      @(posedge mclk_i) disable iff (srst_i)
         !srst_i |=> test_mode_o == $past(test_mode_select_i);
   endproperty
   a_mode: assert property (p_mode) else $error("Test mode wrong");

   property p_mf_test;
      @(posedge mclk_i) disable iff (srst_i)
         !srst_i && test_mode_select_i |=> pll_multiply_factor_o == scrs_pkg::MF_TEST_X10;
   endproperty
   a_mf_test: assert property (p_mf_test) else $error("Factor not 6.6");

   property p_clk_out;
      @(posedge mclk_i) disable iff (srst_i)
         sys_clock_out_o == master_clock_o && sdram_clock_out_o == master_clock_o;
   endproperty
   a_clk_out: assert property (p_clk_out) else $error("Clock out out of phase");

   property p_oe;
      @(posedge mclk_i) disable iff (srst_i)
         sys_clock_out_oe_o == clock_out_enable_i;
   endproperty
   a_oe: assert property (p_oe) else $error("Clock out enable wrong");

   property p_scan;
      @(posedge mclk_i) disable iff (srst_i)
         scan_reset_o == !scan_logic_reset_n_i;
   endproperty
   a_scan: assert property (p_scan) else $error("Scan reset wrong");

   property p_glitch;
      @(posedge mclk_i) disable iff (srst_i)
         (!sys_reset_o && global_reset_in_n_i) ##1 s_low_run ##1 global_reset_in_n_i
            |-> !sys_reset_o;
   endproperty
   a_glitch: assert property (p_glitch) else $error("Short pulse reset");

   // Independent run length of low samples; saturates so a long hold never wraps
   logic [7:0] chk_low_reg;

   always_ff @(posedge mclk_i) begin
      if (srst_i || global_reset_in_n_i) begin
         chk_low_reg <= 8'h00;
      end else if (chk_low_reg != 8'hFF) begin
         chk_low_reg <= chk_low_reg + 8'h01;
      end
   end

   // Filter output must match the plain run length, not the state machine's own count
   property p_filter_len;
      @(posedge mclk_i) disable iff (srst_i)
         sys_reset_o == (chk_low_reg >= 8'(scrs_pkg::RST_FILTER_CYCLES));
   endproperty
   a_filter_len: assert property (p_filter_len) else $error("Filter length wrong");

endmodule // scrs_top

// >>> sim/scrs_board.sv
/*
 * Board model: oscillator, PLL output clock and global reset source.
 * Assumes the bench supplies the master clock and the test mode level.
 */
`timescale 1ns/1ps
module scrs_board (
   input  wire logic mclk_i,
   input  wire logic test_mode_i,
   output logic      ext_clk_o,
   output logic      pll_clk_o,
   output logic      rst_n_o
);
   // Clocks start 5 ns off the master edges, so that a sample never races them
   initial begin
      ext_clk_o = 1'b0;
      pll_clk_o = 1'b0;
      rst_n_o   = 1'b1;
      #5;
      fork
         forever #50 ext_clk_o = ~ext_clk_o;
         forever #(test_mode_i ? 7.576 : 10.0) pll_clk_o = ~pll_clk_o;
      join
   end

   // Low pulse of n master clocks; fewer than 64 is too short to count
   task automatic pulse(input int n);
      rst_n_o <= 1'b0;
      repeat (n) @(posedge mclk_i);
      rst_n_o <= 1'b1;
   endtask
endmodule // scrs_board

// >>> sim/tb_system_clock_reset_select.sv
/*
 * Self-checking bench: the driver notes expected values, a watcher compares.
 * Assumes the board model drives the clocks and the global reset pin.
 */
`timescale 1ns/1ps
module tb_system_clock_reset_select;
   typedef struct {int id; logic [7:0] exp;} scrs_note_t;
   logic       mclk_i = 1'b0;
   logic       srst_i, sel, tm, oe, scan_n;
   logic       ext, pll, grst_n, mck, sys_out, oe_o, sdram, use_pll, tm_o, sys_rst, scan_rst;
   logic [6:0] factor;
   int         n_errors, check_count, cyc;
   int         lens[3] = '{8, 63, 64};
   scrs_note_t q[$];
   event       ev;
   string      nm[7] = '{"clocks", "clock_oe", "use_pll", "test_mode", "factor", "sys_reset",
                         "scan_reset"};

   always #10 mclk_i = ~mclk_i;

   scrs_board board (.mclk_i(mclk_i), .test_mode_i(tm), .ext_clk_o(ext), .pll_clk_o(pll),
                     .rst_n_o(grst_n));
   scrs_top DUT (.mclk_i(mclk_i), .srst_i(srst_i), .ext_clock_in_i(ext), .pll_clock_in_i(pll),
      .clock_source_select_i(sel), .test_mode_select_i(tm), .clock_out_enable_i(oe),
      .global_reset_in_n_i(grst_n), .scan_logic_reset_n_i(scan_n), .master_clock_o(mck),
      .sys_clock_out_o(sys_out), .sys_clock_out_oe_o(oe_o), .sdram_clock_out_o(sdram),
      .use_pll_reg_o(use_pll), .test_mode_o(tm_o), .pll_multiply_factor_o(factor),
      .sys_reset_o(sys_rst), .scan_reset_o(scan_rst));

   function automatic logic [7:0] obs(int id);
      case (id)
         0: return 8'({sdram, sys_out, mck});
         1: return 8'(oe_o);
         2: return 8'(use_pll);
         3: return 8'(tm_o);
         4: return 8'(factor);
         5: return 8'(sys_rst);
         default: return 8'(scan_rst);
      endcase
   endfunction

   task automatic note(int id, logic [7:0] e);
      q.push_back('{id, e});
   endtask

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Watcher: takes the oldest notes off when the driver says outputs have settled
   always begin
      scrs_note_t cur;
      @(ev);
      while (q.size() > 0) begin
         cur = q.pop_front();
         check(nm[cur.id], obs(cur.id), cur.exp);
      end
   end

   // Hang guard; the whole run needs about 200 cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         summarize();
      end
   end

   // Main sequence; checks sit on falling edges, where no board clock toggles
   initial begin
      srst_i = 1'b1;
      sel = 1'b1;
      tm = 1'b1;
      oe = 1'b0;
      scan_n = 1'b1;
      void'($urandom(1602));
      repeat (6) @(posedge mclk_i);
      @(negedge mclk_i);
      note(2, 8'h01);
      note(3, 8'h00);
      note(4, 8'(scrs_pkg::MF_NORMAL_X10));
      note(5, 8'h00);
      ->ev;
      @(posedge mclk_i);
      srst_i <= 1'b0;
      tm <= 1'b0;
      $display("reset values test done");
      repeat (16) begin
         @(posedge mclk_i);
         sel <= 1'($urandom);
         oe <= 1'($urandom);
         scan_n <= 1'($urandom);
         @(posedge mclk_i);
         @(negedge mclk_i);
         note(0, 8'({3{sel ? ext : pll}}));
         note(1, 8'(oe));
         note(2, 8'(!sel));
         note(6, 8'(!scan_n));
         ->ev;
      end
      $display("clock select test done");
      // Test mode test runs after the clock checks: the 6.6 factor leaves the PLL clock off phase
      repeat (8) begin
         @(posedge mclk_i);
         tm <= 1'($urandom);
         @(posedge mclk_i);
         @(negedge mclk_i);
         note(3, 8'(tm));
         note(4, tm ? 8'(scrs_pkg::MF_TEST_X10) : 8'(scrs_pkg::MF_NORMAL_X10));
         ->ev;
      end
      $display("test mode test done");
      // A short glitch, the longest refused pulse, then the shortest accepted one
      foreach (lens[i]) begin
         @(posedge mclk_i);
         board.pulse(lens[i]);
         @(negedge mclk_i);
         note(5, 8'(lens[i] >= scrs_pkg::RST_FILTER_CYCLES));
         ->ev;
      end
      @(posedge mclk_i);
      @(negedge mclk_i);
      note(5, 8'h00);
      ->ev;
      $display("reset filter test done");
      @(posedge mclk_i);
      summarize();
   end
endmodule // tb_system_clock_reset_select
